/* File: common/fsi_pkg.sv */
// Package of shared constants and carrier types for the framer status and interrupt block.
// Assumes a single 40 MHz system clock and a host port already in that clock domain.
package fsi_pkg;

    // ==========================================================
    // Geometry
    localparam int NUM_FRAMERS = 4;
    localparam int BYTE_W      = 8;

    // ==========================================================
    // Per-framer register offsets
    localparam logic [7:0] ADDR_STAT_ONE  = 8'h06;
    localparam logic [7:0] ADDR_STAT_TWO  = 8'h07;
    localparam logic [7:0] ADDR_RX_INFO   = 8'h08;
    localparam logic [7:0] ADDR_MASK_ONE  = 8'h16;
    localparam logic [7:0] ADDR_MASK_TWO  = 8'h17;
    localparam logic [7:0] ADDR_CTL_SIX   = 8'h1d;
    localparam logic [7:0] ADDR_SYNC_STAT = 8'h1e;
    localparam logic [7:0] ADDR_HDLC_STAT = 8'h20;
    localparam logic [7:0] ADDR_HDLC_MASK = 8'h21;
    // Global status answers anywhere with the top two address bits set
    localparam logic [1:0] GIRQ_PAGE      = 2'h3;

    // ==========================================================
    // Control register six fields, reset values and unmapped read data
    localparam int         CTL_TX_SRC     = 2;
    localparam int         CTL_RX_ES_RST  = 1;
    localparam int         CTL_TX_ES_RST  = 0;
    localparam logic [7:0] CTL_SIX_USED   = 8'h07;
    localparam logic [7:0] CTL_SIX_RESET  = 8'h00;
    localparam logic [7:0] MASK_RESET     = 8'h00;
    localparam logic [7:0] RD_UNMAPPED    = 8'h00;

    // ==========================================================
    // Status bit classes: change-of-state alarms sit in the low nibble of status one
    localparam logic [7:0] STAT_ONE_COS   = 8'h0f;
    localparam logic [7:0] NO_COS         = 8'h00;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] stat_one;
        logic [7:0] stat_two;
        logic [7:0] rx_info;
        logic [7:0] hdlc_stat;
        logic [7:0] sync_stat;
    } fsi_stat_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] frm;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fsi_port_t;

endpackage

/* File: design/fsi_latch_reg.sv */
// Latched status byte with write-refresh view, clear on read and masked interrupt request.
// Assumes set inputs and strobes come from logic on sys_clk; strobes are one-cycle pulses.
`timescale 1ns/1ps
module fsi_latch_reg #(
    parameter logic [7:0] COS_MASK = 8'h00
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] set_in,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_mask,
    input  wire logic       rd_en,
    input  wire logic [7:0] irq_mask,
    output logic      [7:0] view,
    output logic            irq_pend
);

    logic [7:0] latch;
    logic [7:0] prev;
    logic [7:0] cos_pend;
    logic [7:0] sel;
    logic [7:0] cos_evt;
    logic [7:0] next_latch;
    logic [7:0] next_view;
    logic [7:0] next_cos_pend;
    logic [7:0] next_sel;
    logic       next_irq_pend;

    // ==========================================================
    // Next state
    always_comb begin
        cos_evt       = (set_in ^ prev) & COS_MASK;
        next_latch    = latch | set_in;
        next_view     = view;
        next_sel      = sel;
        next_cos_pend = cos_pend | cos_evt;
        if (wr_en) begin
            next_view  = (view & ~wr_mask) | ((latch | set_in) & wr_mask);
            next_latch = (latch & ~wr_mask) | set_in;
            next_sel   = wr_mask;
        end
        if (rd_en) begin
            next_view     = 8'h00;
            next_cos_pend = (cos_pend & ~sel) | cos_evt;
        end
        next_irq_pend = |(((((next_latch | next_view) & ~COS_MASK)) | next_cos_pend)
                          & irq_mask);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            latch    <= 8'h00;
            prev     <= 8'h00;
            cos_pend <= 8'h00;
            sel      <= 8'h00;
            view     <= 8'h00;
            irq_pend <= 1'b0;
        end else begin
            latch    <= next_latch;
            prev     <= set_in;
            cos_pend <= next_cos_pend;
            sel      <= next_sel;
            view     <= next_view;
            irq_pend <= next_irq_pend;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    latch_sticky_a: assert property (
        !wr_en ##0 set_in[7] |=> latch[7])
        else $error("set bit not latched");
    refresh_view_a: assert property (
        wr_en && !rd_en |=> (view & $past(wr_mask)) == ($past(latch | set_in) & $past(wr_mask))
                         && (view & ~$past(wr_mask)) == ($past(view) & ~$past(wr_mask)))
        else $error("write did not refresh view");
    cos_irq_a: assert property (
        |(cos_evt & irq_mask) |=> irq_pend)
        else $error("alarm change raised no request");

endmodule // fsi_latch_reg

/* File: design/fsi_status_irq.sv */
// Status, mask and control logic of four framers with one shared active-low interrupt.
// Assumes the host port and status inputs are produced by logic on sys_clk.
`timescale 1ns/1ps
module fsi_status_irq #(
    parameter int NUM_FRAMERS = fsi_pkg::NUM_FRAMERS
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire fsi_pkg::fsi_port_t     host_port,
    input  wire fsi_pkg::fsi_stat_t     stat_in [NUM_FRAMERS],
    output logic [7:0]                  rd_data,
    output logic                        int_n,
    output logic [NUM_FRAMERS-1:0]      tx_clock_source_sel,
    output logic [NUM_FRAMERS-1:0]      tx_clock_loss_en,
    output logic [NUM_FRAMERS-1:0]      rx_elastic_reset,
    output logic [NUM_FRAMERS-1:0]      tx_elastic_reset
);

    // The global status byte has room for exactly four framers
    if (NUM_FRAMERS != fsi_pkg::NUM_FRAMERS) begin : g_bad_cfg
        $error("global status byte holds exactly four framers");
    end

    logic [7:0]             mask_one      [NUM_FRAMERS];
    logic [7:0]             mask_two      [NUM_FRAMERS];
    logic [7:0]             hdlc_mask     [NUM_FRAMERS];
    logic [7:0]             ctl_six       [NUM_FRAMERS];
    logic [7:0]             next_mask_one [NUM_FRAMERS];
    logic [7:0]             next_mask_two [NUM_FRAMERS];
    logic [7:0]             next_hdlc_mask[NUM_FRAMERS];
    logic [7:0]             next_ctl_six  [NUM_FRAMERS];
    logic [NUM_FRAMERS-1:0] next_src_sel;
    logic [NUM_FRAMERS-1:0] next_loss_en;
    logic [NUM_FRAMERS-1:0] next_rx_es;
    logic [NUM_FRAMERS-1:0] next_tx_es;
    logic [7:0]             view_one      [NUM_FRAMERS];
    logic [7:0]             view_two      [NUM_FRAMERS];
    logic [7:0]             view_info     [NUM_FRAMERS];
    logic [7:0]             view_hdlc     [NUM_FRAMERS];
    logic [NUM_FRAMERS-1:0] pend_one;
    logic [NUM_FRAMERS-1:0] pend_two;
    logic [NUM_FRAMERS-1:0] pend_info;
    logic [NUM_FRAMERS-1:0] pend_hdlc;
    logic [7:0]             girq;
    logic [7:0]             next_rd_data;
    logic                   next_int_n;
    logic                   girq_hit;

    // ==========================================================
    // Per-framer latched status registers
    for (genvar f = 0; f < NUM_FRAMERS; f++) begin : g_frm
        logic sel;
        assign sel = (host_port.frm == 2'(f));

        fsi_latch_reg #(.COS_MASK(fsi_pkg::STAT_ONE_COS)) u_one (
            .sys_clk  (sys_clk),
            .rst      (rst),
            .set_in   (stat_in[f].stat_one),
            .wr_en    (host_port.wr && sel && host_port.addr == fsi_pkg::ADDR_STAT_ONE),
            .wr_mask  (host_port.wdata),
            .rd_en    (host_port.rd && sel && host_port.addr == fsi_pkg::ADDR_STAT_ONE),
            .irq_mask (mask_one[f]),
            .view     (view_one[f]),
            .irq_pend (pend_one[f])
        );
        fsi_latch_reg #(.COS_MASK(fsi_pkg::NO_COS)) u_two (
            .sys_clk  (sys_clk),
            .rst      (rst),
            .set_in   (stat_in[f].stat_two),
            .wr_en    (host_port.wr && sel && host_port.addr == fsi_pkg::ADDR_STAT_TWO),
            .wr_mask  (host_port.wdata),
            .rd_en    (host_port.rd && sel && host_port.addr == fsi_pkg::ADDR_STAT_TWO),
            .irq_mask (mask_two[f]),
            .view     (view_two[f]),
            .irq_pend (pend_two[f])
        );
        // Receive info bits latch but never reach the interrupt
        fsi_latch_reg #(.COS_MASK(fsi_pkg::NO_COS)) u_info (
            .sys_clk  (sys_clk),
            .rst      (rst),
            .set_in   (stat_in[f].rx_info),
            .wr_en    (host_port.wr && sel && host_port.addr == fsi_pkg::ADDR_RX_INFO),
            .wr_mask  (host_port.wdata),
            .rd_en    (host_port.rd && sel && host_port.addr == fsi_pkg::ADDR_RX_INFO),
            .irq_mask (8'h00),
            .view     (view_info[f]),
            .irq_pend (pend_info[f])
        );
        fsi_latch_reg #(.COS_MASK(fsi_pkg::NO_COS)) u_hdlc (
            .sys_clk  (sys_clk),
            .rst      (rst),
            .set_in   (stat_in[f].hdlc_stat),
            .wr_en    (host_port.wr && sel && host_port.addr == fsi_pkg::ADDR_HDLC_STAT),
            .wr_mask  (host_port.wdata),
            .rd_en    (host_port.rd && sel && host_port.addr == fsi_pkg::ADDR_HDLC_STAT),
            .irq_mask (hdlc_mask[f]),
            .view     (view_hdlc[f]),
            .irq_pend (pend_hdlc[f])
        );
        assign girq[2*f]   = pend_one[f] | pend_two[f];
        assign girq[2*f+1] = pend_hdlc[f];
    end

    // ==========================================================
    // Masks and control register six
    always_comb begin
        for (int f = 0; f < NUM_FRAMERS; f++) begin
            next_mask_one[f]  = mask_one[f];
            next_mask_two[f]  = mask_two[f];
            next_hdlc_mask[f] = hdlc_mask[f];
            next_ctl_six[f]   = ctl_six[f];
            if (host_port.wr && host_port.frm == f[1:0]) begin
                case (host_port.addr)
                    fsi_pkg::ADDR_MASK_ONE: begin
                        next_mask_one[f] = host_port.wdata;
                    end
                    fsi_pkg::ADDR_MASK_TWO: begin
                        next_mask_two[f] = host_port.wdata;
                    end
                    fsi_pkg::ADDR_HDLC_MASK: begin
                        next_hdlc_mask[f] = host_port.wdata;
                    end
                    fsi_pkg::ADDR_CTL_SIX: begin
                        next_ctl_six[f] = host_port.wdata & fsi_pkg::CTL_SIX_USED;
                    end
                    default: begin
                        next_ctl_six[f] = ctl_six[f];
                    end
                endcase
            end
            next_src_sel[f] = next_ctl_six[f][fsi_pkg::CTL_TX_SRC];
            next_loss_en[f] = ~next_ctl_six[f][fsi_pkg::CTL_TX_SRC];
            next_rx_es[f]   = next_ctl_six[f][fsi_pkg::CTL_RX_ES_RST]
                            & ~ctl_six[f][fsi_pkg::CTL_RX_ES_RST];
            next_tx_es[f]   = next_ctl_six[f][fsi_pkg::CTL_TX_ES_RST]
                            & ~ctl_six[f][fsi_pkg::CTL_TX_ES_RST];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int f = 0; f < NUM_FRAMERS; f++) begin
                mask_one[f]  <= fsi_pkg::MASK_RESET;
                mask_two[f]  <= fsi_pkg::MASK_RESET;
                hdlc_mask[f] <= fsi_pkg::MASK_RESET;
                ctl_six[f]   <= fsi_pkg::CTL_SIX_RESET;
            end
            tx_clock_source_sel <= '0;
            tx_clock_loss_en    <= '1;
            rx_elastic_reset    <= '0;
            tx_elastic_reset    <= '0;
        end else begin
            mask_one            <= next_mask_one;
            mask_two            <= next_mask_two;
            hdlc_mask           <= next_hdlc_mask;
            ctl_six             <= next_ctl_six;
            tx_clock_source_sel <= next_src_sel;
            tx_clock_loss_en    <= next_loss_en;
            rx_elastic_reset    <= next_rx_es;
            tx_elastic_reset    <= next_tx_es;
        end
    end

    // ==========================================================
    // Read data and shared interrupt
    always_comb begin
        girq_hit     = (host_port.addr[7:6] == fsi_pkg::GIRQ_PAGE);
        next_rd_data = rd_data;
        next_int_n   = ~|girq;
        if (host_port.rd) begin
            if (girq_hit) begin
                next_rd_data = girq;
            end else begin
                case (host_port.addr)
                    fsi_pkg::ADDR_STAT_ONE:  next_rd_data = view_one[host_port.frm];
                    fsi_pkg::ADDR_STAT_TWO:  next_rd_data = view_two[host_port.frm];
                    fsi_pkg::ADDR_RX_INFO:   next_rd_data = view_info[host_port.frm];
                    fsi_pkg::ADDR_HDLC_STAT: next_rd_data = view_hdlc[host_port.frm];
                    fsi_pkg::ADDR_SYNC_STAT: next_rd_data = stat_in[host_port.frm].sync_stat;
                    fsi_pkg::ADDR_MASK_ONE:  next_rd_data = mask_one[host_port.frm];
                    fsi_pkg::ADDR_MASK_TWO:  next_rd_data = mask_two[host_port.frm];
                    fsi_pkg::ADDR_HDLC_MASK: next_rd_data = hdlc_mask[host_port.frm];
                    fsi_pkg::ADDR_CTL_SIX:   next_rd_data = ctl_six[host_port.frm];
                    default:                 next_rd_data = fsi_pkg::RD_UNMAPPED;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
            int_n   <= 1'b1;
        end else begin
            rd_data <= next_rd_data;
            int_n   <= next_int_n;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence ctl_wr_s(logic [7:0] val);
        host_port.wr && host_port.frm == 2'h0 && host_port.addr == fsi_pkg::ADDR_CTL_SIX
        && (host_port.wdata & fsi_pkg::CTL_SIX_USED) == val;
    endsequence

    sequence quiet_ctl_s;
        !(host_port.wr && host_port.frm == 2'h0 && host_port.addr == fsi_pkg::ADDR_CTL_SIX);
    endsequence

    tx_src_rx_a: assert property (
        ctl_wr_s(8'h04) |=> tx_clock_source_sel[0] && !tx_clock_loss_en[0])
        else $error("receive clock not selected");
    tx_src_line_a: assert property (
        ctl_wr_s(8'h00) |=> !tx_clock_source_sel[0] && tx_clock_loss_en[0])
        else $error("line clock not selected");
    rx_es_pulse_a: assert property (
        ctl_wr_s(8'h07) ##0 !ctl_six[0][fsi_pkg::CTL_RX_ES_RST]
        |=> rx_elastic_reset[0] ##1 !rx_elastic_reset[0])
        else $error("receive store reset not one pulse");
    tx_es_pulse_a: assert property (
        tx_elastic_reset[0] |-> $past(ctl_six[0][fsi_pkg::CTL_TX_ES_RST], 1) == 1'b0
                              && ctl_six[0][fsi_pkg::CTL_TX_ES_RST])
        else $error("transmit store reset without rising bit");
    sync_live_a: assert property (
        host_port.rd && host_port.addr == fsi_pkg::ADDR_SYNC_STAT && host_port.frm == 2'h1
        |=> rd_data == $past(stat_in[1].sync_stat))
        else $error("sync status not live");
    girq_read_a: assert property (
        host_port.rd && host_port.addr[7:6] == fsi_pkg::GIRQ_PAGE |=> rd_data == $past(girq))
        else $error("global status read wrong");
    int_follow_a: assert property (
        (|girq) ##1 (|girq) |-> !int_n)
        else $error("pending request left interrupt high");
    int_release_a: assert property (
        !(|girq) [*2] |-> int_n)
        else $error("interrupt held with nothing pending");

endmodule // fsi_status_irq

/* File: sim/fsi_host_model.sv */
// Host processor model that drives the parallel control port of the status block.
// Assumes one sys_clk domain; each access starts 1 ns after a rising edge.
`timescale 1ns/1ps
module fsi_host_model (
    input  wire logic          sys_clk,
    input  wire logic [7:0]    rd_data,
    output var fsi_pkg::fsi_port_t host_port
);
    initial begin
        host_port = '0;
    end

    // ==========================================================
    // Bus cycles
    // One strobe cycle, then a released cycle; read data is taken after it settles
    task automatic xfer(input logic w, input logic [1:0] f, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk) #1;
        host_port.wr    = w;
        host_port.rd    = !w;
        host_port.frm   = f;
        host_port.addr  = a;
        host_port.wdata = d;
        @(posedge sys_clk) #1;
        host_port.wr    = 1'b0;
        host_port.rd    = 1'b0;
        // Released address and data lines do not keep their last value
        host_port.addr  = ~host_port.addr;
        host_port.wdata = ~host_port.wdata;
        @(posedge sys_clk) #1;
        q = rd_data;
    endtask

    // Mask write, read, then write back the read value under the mask
    task automatic poll(input logic [1:0] f, input logic [7:0] a, input logic [7:0] m,
                        output logic [7:0] q);
        logic [7:0] junk;
        xfer(1'b1, f, a, m, junk);
        xfer(1'b0, f, a, 8'h00, q);
        xfer(1'b1, f, a, q & m, junk);
    endtask

    // Elastic store resets are pulsed high then cleared, never left set
    task automatic es_toggle(input logic [1:0] f, input logic sel);
        logic [7:0] junk;
        xfer(1'b1, f, fsi_pkg::ADDR_CTL_SIX, {5'h00, sel, 2'b11}, junk);
        xfer(1'b1, f, fsi_pkg::ADDR_CTL_SIX, {5'h00, sel, 2'b00}, junk);
    endtask
endmodule // fsi_host_model

/* File: sim/fsi_status_irq_tb.sv */
// Self-checking bench for the four-framer status and interrupt block.
// Assumes the host model in fsi_host_model and a 40 MHz sys_clk.
`timescale 1ns/1ps
module fsi_status_irq_tb;
    localparam int NF = fsi_pkg::NUM_FRAMERS;
    localparam logic [7:0] ST_A [3] = '{fsi_pkg::ADDR_STAT_TWO, fsi_pkg::ADDR_HDLC_STAT,
                                        fsi_pkg::ADDR_RX_INFO};
    localparam logic [7:0] MK_A [2] = '{fsi_pkg::ADDR_MASK_TWO, fsi_pkg::ADDR_HDLC_MASK};

    logic               sys_clk;
    logic               rst;
    fsi_pkg::fsi_port_t host_port;
    fsi_pkg::fsi_stat_t stat_in [NF];
    logic [7:0]         rd_data;
    logic               int_n;
    logic [NF-1:0]      src_sel;
    logic [NF-1:0]      loss_en;
    logic [NF-1:0]      rx_rst;
    logic [NF-1:0]      tx_rst;
    int                 rx_cnt [NF];
    int                 tx_cnt [NF];
    int                 fail_count;
    int                 comparisons;

    fsi_status_irq #(.NUM_FRAMERS(NF)) u_fsi_status_irq (
        .sys_clk(sys_clk), .rst(rst), .host_port(host_port), .stat_in(stat_in),
        .rd_data(rd_data), .int_n(int_n), .tx_clock_source_sel(src_sel),
        .tx_clock_loss_en(loss_en), .rx_elastic_reset(rx_rst), .tx_elastic_reset(tx_rst)
    );

    fsi_host_model u_fsi_host_model (
        .sys_clk(sys_clk), .rd_data(rd_data), .host_port(host_port)
    );

    // ==========================================================
    // Clock and reset pulse counting
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        for (int k = 0; k < NF; k++) begin
            rx_cnt[k] <= rx_cnt[k] + int'(rx_rst[k]);
            tx_cnt[k] <= tx_cnt[k] + int'(tx_rst[k]);
        end
    end

    // ==========================================================
    // Helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic set_ev(input int f, input int h, input logic [7:0] v);
        case (h)
            0: stat_in[f].stat_two = v;
            1: stat_in[f].hdlc_stat = v;
            default: stat_in[f].rx_info = v;
        endcase
    endtask

    task automatic pulse(input int f, input int h, input logic [7:0] v);
        set_ev(f, h, v);
        tick(1);
        set_ev(f, h, 8'h00);
    endtask

    function automatic logic [7:0] girq_bit(input int f, input int h);
        return 8'(1 << (2 * f + h));
    endfunction

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial begin : main
        logic [7:0] q;
        logic [7:0] r;
        logic [7:0] m;
        rst = 1'b1;
        fail_count = 0;
        comparisons = 0;
        for (int k = 0; k < NF; k++) stat_in[k] = '0;
        void'($urandom(32'h1c40ea6a));
        repeat (8) @(posedge sys_clk);
        #1 rst = 1'b0;
        check(rd_data, 8'h00);
        check(8'(int_n), 8'h01);
        check(8'(src_sel), 8'h00);
        check(8'(loss_en), 8'({NF{1'b1}}));
        u_fsi_host_model.xfer(1'b0, 2'd0, 8'h30, 8'h00, q);
        check(q, fsi_pkg::RD_UNMAPPED);
        $display("test reset done");

        for (int k = 0; k < NF; k++) begin
            u_fsi_host_model.es_toggle(2'(k), 1'b1);
            check(8'(src_sel), 8'(1 << k));
            check(8'(loss_en), 8'(~(1 << k) & {NF{1'b1}}));
            check(8'(rx_cnt[k] + 16 * tx_cnt[k]), 8'h11);
            u_fsi_host_model.xfer(1'b0, 2'(k), fsi_pkg::ADDR_CTL_SIX, 8'h00, q);
            check(q, 8'h04);
            u_fsi_host_model.xfer(1'b1, 2'(k), fsi_pkg::ADDR_CTL_SIX, 8'hf8, q);
            u_fsi_host_model.xfer(1'b0, 2'(k), fsi_pkg::ADDR_CTL_SIX, 8'h00, q);
            check(q, 8'h00);
            check(8'(src_sel), 8'h00);
            check(8'(loss_en), 8'({NF{1'b1}}));
        end
        $display("test control done");

        for (int k = 0; k < NF; k++) begin
            r = 8'($urandom);
            stat_in[k].sync_stat = r;
            u_fsi_host_model.xfer(1'b1, 2'(k), fsi_pkg::ADDR_SYNC_STAT, ~r, q);
            r = 8'($urandom);
            stat_in[k].sync_stat = r;
            u_fsi_host_model.xfer(1'b0, 2'(k), fsi_pkg::ADDR_SYNC_STAT, 8'h00, q);
            check(q, r);
        end
        $display("test sync done");

        for (int k = 0; k < NF; k++) begin
            for (int h = 0; h < 3; h++) begin
                r = 8'($urandom) | 8'h01;
                m = 8'($urandom);
                pulse(k, h, r);
                tick(3);
                check(8'(int_n), 8'h01);
                u_fsi_host_model.poll(2'(k), ST_A[h], m, q);
                check(q, r & m);
                u_fsi_host_model.poll(2'(k), ST_A[h], 8'hff, q);
                check(q, r & ~m);
                u_fsi_host_model.poll(2'(k), ST_A[h], 8'hff, q);
                check(q, 8'h00);
                if (h < 2) begin
                    u_fsi_host_model.xfer(1'b1, 2'(k), MK_A[h], 8'hff, q);
                    u_fsi_host_model.xfer(1'b0, 2'(k), MK_A[h], 8'h00, q);
                    check(q, 8'hff);
                    pulse(k, h, r);
                    tick(3);
                    check(8'(int_n), 8'h00);
                    u_fsi_host_model.xfer(1'b0, 2'(k), 8'hc0 | 8'($urandom % 64), 8'h00, q);
                    check(q, girq_bit(k, h));
                    u_fsi_host_model.poll(2'(k), ST_A[h], 8'hff, q);
                    check(8'(int_n), 8'h01);
                    u_fsi_host_model.xfer(1'b1, 2'(k), MK_A[h], 8'h00, q);
                end
            end
        end
        $display("test events done");

        for (int k = 0; k < NF; k++) begin
            m = 8'(1 << ($urandom % 4));
            u_fsi_host_model.xfer(1'b1, 2'(k), fsi_pkg::ADDR_MASK_ONE, fsi_pkg::STAT_ONE_COS, q);
            u_fsi_host_model.xfer(1'b0, 2'(k), fsi_pkg::ADDR_MASK_ONE, 8'h00, q);
            check(q, fsi_pkg::STAT_ONE_COS);
            for (int lv = 1; lv >= 0; lv--) begin
                stat_in[k].stat_one = (lv == 1) ? m : 8'h00;
                tick(3);
                check(8'(int_n), 8'h00);
                u_fsi_host_model.poll(2'(k), fsi_pkg::ADDR_STAT_ONE, m, q);
                check(q, m);
                check(8'(int_n), 8'h01);
            end
            u_fsi_host_model.poll(2'(k), fsi_pkg::ADDR_STAT_ONE, m, q);
            check(q, 8'h00);
            u_fsi_host_model.xfer(1'b1, 2'(k), fsi_pkg::ADDR_MASK_ONE, 8'h00, q);
        end
        $display("test alarms done");
        conclude();
    end
endmodule // fsi_status_irq_tb
